/* File: par_restart_ctrl.sv */
// Protection auto-restart sequencer with a Wishbone register port
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "par_cfg.svh"
// Function
// - Four restart variants, each selected by one or more fault sources
// - Odd-skip odd cycles: no evaluation, no switching
// - Odd-skip even cycles evaluate, switch, resume there
// - Odd-skip non-switching: even cycles evaluate, never switch
// - Startup overvoltage plus overload in soft start
// - Hard overvoltage enters odd-skip restart from normal run with the enable bit set
// - Over-temperature enters odd-skip non-switching restart
// - Supply lockout off gives plain auto restart
// - External protect input gives non-switching restart
// - Brownout held 30 us gives non-switching restart
// - Overload starts 20 ms built-in blanking timer
// - Extended cycle: discharge, charge, count
// - Count 256 stops, spike delay, odd-skip restart
// - Brownout restart cycles issue no switching pulses
module par_restart_ctrl
#(
   parameter int BUILTIN_CYCLES = `PAR_BLANK_CYCLES
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic supplyOk,
   input wire logic startupOvervoltage,
   input wire logic hardOvervoltage,
   input wire logic overTemp,
   input wire logic extProtectLow,
   input wire logic brownoutLow,
   input wire logic softStartActive,
   input wire logic overloadComparator,
   input wire logic pinHighComparator,
   input wire logic pinLowComparator,
   output logic gateEnable,
   output logic startupCellOn,
   output logic chargeSwitch,
   output logic dischargeSwitch,
   output logic extBlankDone,
   output logic cycleOdd,
   output par_pkg::par_mode_e protectMode
);
   import par_pkg::*;

   par_blank_if blk ();

   par_state_e state_reg;
   par_state_e state_next;
   par_mode_e mode_reg;
   par_mode_e mode_next;
   logic oddCycle_reg;
   logic oddCycle_next;
   logic gate_reg;
   logic gate_next;
   logic supplyPrev_reg;
   logic [9:0] brownCnt_reg;
   logic brownQual_reg;
   logic enable_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;

   // ----------------------------------------
   // Fault decode
   // ----------------------------------------
   // Supply lockout edges frame each restart cycle
   wire lockoutOff = supplyPrev_reg && !supplyOk;
   wire lockoutOn = !supplyPrev_reg && supplyOk;
   wire ovpStart = startupOvervoltage && overloadComparator
      && softStartActive;
   wire osarFault = hardOvervoltage || ovpStart || blk.trip;
   wire nsarFault = extProtectLow || brownQual_reg;
   wire anyFault = osarFault || overTemp || nsarFault;
   // One variant per source, most severe first
   wire par_mode_e faultMode = osarFault ? MODE_OSAR :
      overTemp ? MODE_OSNS : MODE_NSAR;
   wire oddSkipMode = mode_reg == MODE_OSAR || mode_reg == MODE_OSNS;
   wire switchMode = mode_reg == MODE_AR || mode_reg == MODE_OSAR;
   wire skipCycle = oddSkipMode && oddCycle_reg;
   // Fault of the latched source still present at evaluation
   wire stillFaulty = mode_reg == MODE_OSAR ?
      (hardOvervoltage || overloadComparator) :
      mode_reg == MODE_OSNS ? overTemp :
      mode_reg == MODE_NSAR ? nsarFault : 1'b0;

   // ----------------------------------------
   // Restart sequencer
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      mode_next = mode_reg;
      oddCycle_next = oddCycle_reg;
      gate_next = gate_reg;
      case (state_reg)
         ST_NORMAL:
            if (lockoutOff)
            begin
               state_next = ST_RECHARGE;
               mode_next = MODE_AR;
               oddCycle_next = 1'b1;
               gate_next = 1'b0;
            end
            else if (enable_reg && anyFault)
            begin
               state_next = ST_WAIT_OFF;
               mode_next = faultMode;
               gate_next = 1'b0;
            end
         ST_WAIT_OFF:
            if (lockoutOff)
            begin
               state_next = ST_RECHARGE;
               oddCycle_next = 1'b1;
            end
         ST_RECHARGE:
            if (lockoutOn)
            begin
               if (skipCycle)
                  state_next = ST_RUN;
               else if (!stillFaulty)
               begin
                  state_next = ST_NORMAL;
                  mode_next = MODE_NONE;
                  oddCycle_next = 1'b0;
                  gate_next = 1'b1;
               end
               else
               begin
                  state_next = ST_RUN;
                  gate_next = switchMode;
               end
            end
         ST_RUN:
            if (lockoutOff)
            begin
               state_next = ST_RECHARGE;
               oddCycle_next = !oddCycle_reg;
               gate_next = 1'b0;
            end
         default: state_next = ST_NORMAL;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= ST_NORMAL;
         mode_reg <= MODE_NONE;
         oddCycle_reg <= 1'b0;
         gate_reg <= 1'b0;
         supplyPrev_reg <= 1'b1; // Idle level: no false supply edge
      end
      else
      begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         oddCycle_reg <= oddCycle_next;
         gate_reg <= gate_next;
         supplyPrev_reg <= supplyOk;
      end
   end

   // Brownout must stay low for the qualification time
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         brownCnt_reg <= 10'h0;
         brownQual_reg <= 1'b0;
      end
      else
      begin
         brownCnt_reg <= !brownoutLow ? 10'h0 :
            brownQual_reg ? brownCnt_reg : brownCnt_reg + 10'h1;
         brownQual_reg <= brownoutLow &&
            brownCnt_reg >= 10'(`PAR_BROWN_CYCLES - 1);
      end
   end

   // ----------------------------------------
   // Blanking timer
   // ----------------------------------------
   assign blk.overload = overloadComparator;
   assign blk.pinHigh = pinHighComparator;
   assign blk.pinLow = pinLowComparator;
   assign blk.clear = state_reg != ST_NORMAL;

   par_blank_timer #(.BUILTIN_CYCLES(BUILTIN_CYCLES)) blank_u
   (
      .clk(clk),
      .reset_n(reset_n),
      .bus(blk)
   );

   // Pin outputs
   assign gateEnable = gate_reg;
   assign startupCellOn = state_reg == ST_RECHARGE;
   assign chargeSwitch = blk.chargeSwitch;
   assign dischargeSwitch = blk.dischargeSwitch;
   assign extBlankDone = blk.extDone;
   assign cycleOdd = oddCycle_reg;
   assign protectMode = mode_reg;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   wire request = wb_cyc_i && wb_stb_i;
   wire ctrlWrite = request && ack_reg && wb_we_i && wb_sel_i[0]
      && wb_adr_i == `PAR_ADDR_CTRL;
   wire [31:0] statusWord = {22'h0, blk.extDone, brownQual_reg, gate_reg,
      oddCycle_reg, state_reg, 1'b0, mode_reg};
   wire [31:0] readMux = wb_adr_i == `PAR_ADDR_CTRL ? {31'h0, enable_reg} :
      wb_adr_i == `PAR_ADDR_STATUS ? statusWord :
      wb_adr_i == `PAR_ADDR_EXTCNT ? {23'h0, blk.extCount} : 32'h0;

   // Ack one cycle after the request; write lands on the ack edge
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0;
         enable_reg <= `PAR_CTRL_RESET;
      end
      else
      begin
         ack_reg <= request && !ack_reg;
         if (request && !ack_reg)
            rdata_reg <= readMux;
         if (ctrlWrite)
            enable_reg <= wb_dat_i[`PAR_CTRL_ENABLE_BIT];
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_decide;
      state_reg == ST_RECHARGE && lockoutOn;
   endsequence

   a_skip_no_gate: assert property (
      s_decide ##0 skipCycle |=> state_reg == ST_RUN && !gateEnable
      ##1 (!gateEnable || lockoutOff))
      else $error("Switching in a skipped odd cycle");
   a_resume_even: assert property (
      s_decide ##0 oddSkipMode ##0 !stillFaulty
      |=> (state_reg == ST_NORMAL) != $past(oddCycle_reg))
      else $error("Odd-skip resume on an odd cycle");
   a_nsw_no_gate: assert property (
      (mode_reg == MODE_OSNS || mode_reg == MODE_NSAR) |-> !gateEnable)
      else $error("Pulses in a non-switching restart");
   a_ovp_start: assert property (
      state_reg == ST_NORMAL && enable_reg && !lockoutOff && ovpStart
      |=> protectMode == MODE_OSAR && !gateEnable)
      else $error("Startup overvoltage not latched");
   a_hard_ovp: assert property (
      state_reg == ST_NORMAL && enable_reg && !lockoutOff && hardOvervoltage
      |=> protectMode == MODE_OSAR && state_reg == ST_WAIT_OFF)
      else $error("Hard overvoltage not latched");
   a_over_temp: assert property (
      state_reg == ST_NORMAL && enable_reg && !lockoutOff && !osarFault
      && overTemp |=> protectMode == MODE_OSNS)
      else $error("Over-temperature variant wrong");
   a_uv_plain: assert property (
      state_reg == ST_NORMAL && lockoutOff
      |=> protectMode == MODE_AR && startupCellOn && cycleOdd)
      else $error("Lockout did not start plain restart");
   a_brown_qual: assert property (
      !brownoutLow |=> !brownQual_reg ##1 !brownQual_reg)
      else $error("Brownout qualified too early");
   a_cycle_one: assert property (
      state_reg == ST_WAIT_OFF && lockoutOff |=> cycleOdd && startupCellOn)
      else $error("First restart cycle not numbered one");
endmodule
`default_nettype wire

/* File: par_cfg.svh */
// Constants for the protection auto-restart controller
`ifndef PAR_CFG_SVH
`define PAR_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PAR_CLK_HZ 25000000
`define PAR_BLANK_MS 20
`define PAR_BLANK_CYCLES ((`PAR_BLANK_MS * `PAR_CLK_HZ) / 1000)
`define PAR_SPIKE_US 30
`define PAR_SPIKE_CYCLES ((`PAR_SPIKE_US * `PAR_CLK_HZ + 999999) / 1000000)
`define PAR_BROWN_US 30
`define PAR_BROWN_CYCLES ((`PAR_BROWN_US * `PAR_CLK_HZ + 999999) / 1000000)
`define PAR_EXT_COUNT 256

// ----------------------------------------
// Register map
// ----------------------------------------
`define PAR_ADDR_CTRL 8'h00
`define PAR_ADDR_STATUS 8'h04
`define PAR_ADDR_EXTCNT 8'h08
`define PAR_CTRL_ENABLE_BIT 0
`define PAR_CTRL_RESET 1'h1

`endif

/* File: par_pkg.sv */
// Types for the protection auto-restart controller
package par_pkg;
   typedef enum logic [2:0] {MODE_NONE, MODE_AR, MODE_NSAR, MODE_OSAR,
      MODE_OSNS} par_mode_e;
   typedef enum logic [1:0] {ST_NORMAL, ST_WAIT_OFF, ST_RECHARGE,
      ST_RUN} par_state_e;
   typedef enum logic [2:0] {BL_IDLE, BL_BUILTIN, BL_DISCH, BL_CHARGE,
      BL_DONE, BL_TRIPPED} par_blank_e;
endpackage

/* File: par_blank_if.sv */
// Signals between the restart sequencer and the blanking timer
`timescale 1ns/1ns
`default_nettype none
interface par_blank_if;
   logic overload;
   logic pinHigh;
   logic pinLow;
   logic clear;
   logic chargeSwitch;
   logic dischargeSwitch;
   logic extDone;
   logic trip;
   logic [8:0] extCount;
   modport ctrl (output overload, pinHigh, pinLow, clear,
      input chargeSwitch, dischargeSwitch, extDone, trip, extCount);
   modport blank (input overload, pinHigh, pinLow, clear,
      output chargeSwitch, dischargeSwitch, extDone, trip, extCount);
endinterface
`default_nettype wire

/* File: par_blank_timer.sv */
// Overload blanking: built-in timer, extended counter and spike delay
`timescale 1ns/1ns
`default_nettype none
`include "par_cfg.svh"
module par_blank_timer
#(
   parameter int BUILTIN_CYCLES = `PAR_BLANK_CYCLES
)
(
   input wire logic clk,
   input wire logic reset_n,
   par_blank_if.blank bus
);
   import par_pkg::*;

   par_blank_e state_reg;
   par_blank_e state_next;
   logic [19:0] builtinCnt_reg;
   logic [19:0] builtinCnt_next;
   logic [8:0] extCount_reg;
   logic [8:0] extCount_next;
   logic [9:0] spikeCnt_reg;
   logic [9:0] spikeCnt_next;

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   // Dropped overload or clear request zeroes all counters
   wire abort = !bus.overload || bus.clear;
   wire builtinEnd = builtinCnt_reg == 20'(BUILTIN_CYCLES - 1);
   wire lastCharge = extCount_reg == 9'(`PAR_EXT_COUNT - 1);
   wire spikeEnd = spikeCnt_reg == 10'(`PAR_SPIKE_CYCLES - 1);

   // Next state and counter values
   always_comb
   begin
      state_next = state_reg;
      builtinCnt_next = builtinCnt_reg;
      extCount_next = extCount_reg;
      spikeCnt_next = spikeCnt_reg;
      if (abort)
      begin
         state_next = BL_IDLE;
         builtinCnt_next = 20'h0;
         extCount_next = 9'h0;
         spikeCnt_next = 10'h0;
      end
      else
      begin
         case (state_reg)
            BL_IDLE: state_next = BL_BUILTIN;
            BL_BUILTIN:
               if (builtinEnd)
                  state_next = BL_DISCH;
               else
                  builtinCnt_next = builtinCnt_reg + 20'h1;
            BL_DISCH:
               if (bus.pinLow)
                  state_next = BL_CHARGE;
            BL_CHARGE:
               if (bus.pinHigh)
               begin
                  extCount_next = extCount_reg + 9'h1;
                  state_next = lastCharge ? BL_DONE : BL_DISCH;
               end
            BL_DONE:
               if (spikeEnd)
                  state_next = BL_TRIPPED;
               else
                  spikeCnt_next = spikeCnt_reg + 10'h1;
            BL_TRIPPED: state_next = BL_TRIPPED;
            default: state_next = BL_IDLE;
         endcase
      end
   end

   // State and counters
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= BL_IDLE;
         builtinCnt_reg <= 20'h0;
         extCount_reg <= 9'h0;
         spikeCnt_reg <= 10'h0;
      end
      else
      begin
         state_reg <= state_next;
         builtinCnt_reg <= builtinCnt_next;
         extCount_reg <= extCount_next;
         spikeCnt_reg <= spikeCnt_next;
      end
   end

   // Switch and status decode
   assign bus.dischargeSwitch = state_reg == BL_DISCH;
   assign bus.chargeSwitch = state_reg == BL_CHARGE;
   assign bus.extDone = state_reg == BL_DONE || state_reg == BL_TRIPPED;
   assign bus.trip = state_reg == BL_DONE && spikeEnd && !abort;
   assign bus.extCount = extCount_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_chargeDone;
      state_reg == BL_CHARGE && bus.pinHigh && !abort;
   endsequence

   a_builtin_start: assert property (
      state_reg == BL_IDLE && bus.overload && !bus.clear
      |=> state_reg == BL_BUILTIN && builtinCnt_reg == 20'h0)
      else $error("Built-in timer did not start on overload");
   a_charge_count: assert property (
      s_chargeDone |=> extCount_reg == $past(extCount_reg) + 9'h1
      && !bus.chargeSwitch)
      else $error("Charge phase did not end with a count step");
   a_ext_done: assert property (
      s_chargeDone ##0 lastCharge |=> bus.extDone && !bus.chargeSwitch
      && !bus.dischargeSwitch)
      else $error("Extended counter did not stop at its final count");
   a_clear_zero: assert property (
      !bus.overload
      |=> builtinCnt_reg == 20'h0 && extCount_reg == 9'h0)
      else $error("Blanking counters not held at zero");
endmodule
`default_nettype wire

/* File: par_afe_model.sv */
// Analog front end model: blanking pin capacitor and its comparators
`timescale 1ns/1ns
`default_nettype none
module par_afe_model
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic slow,
   input wire logic chargeSwitch,
   input wire logic dischargeSwitch,
   output logic pinHigh,
   output logic pinLow
);
   int levelReg;
   int step;
   // Pin voltage in tenths of a volt; a slow pin mimics a big capacitor
   assign step = slow ? 3 : 20;
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         levelReg <= 30;
      else if (dischargeSwitch)
         levelReg <= (levelReg > step) ? levelReg - step : 0;
      else if (chargeSwitch)
         levelReg <= (levelReg + step > 50) ? 50 : levelReg + step;
   end
   // Comparators at the 0.9 V and 4.5 V trip levels
   assign pinLow = levelReg <= 9;
   assign pinHigh = levelReg >= 45;
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the protection auto-restart controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
   errorCnt++; $display("unexpected %s exp %0h got %0h", nm, exp, got); \
   end end
module testbench;
   import par_pkg::*;
   localparam int BLANK = 20;
   logic clk, reset_n, wbCyc, wbStb, wbWe, wbAck, slow;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatI, wbDatO, rd;
   logic supplyOk, startOv, hardOv, overTemp, extLow, brownLow, softStart;
   logic overload, pinHigh, pinLow, gateEnable, cellOn, chargeSw;
   logic dischargeSw, extDone, cycleOdd, prevCh;
   par_mode_e mode;
   int errorCnt, compares, tick, n, pulses;
   // Clock at 25 MHz
   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   par_restart_ctrl #(.BUILTIN_CYCLES(BLANK)) DUT (.clk(clk),
      .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .supplyOk(supplyOk),
      .startupOvervoltage(startOv), .hardOvervoltage(hardOv),
      .overTemp(overTemp), .extProtectLow(extLow), .brownoutLow(brownLow),
      .softStartActive(softStart), .overloadComparator(overload),
      .pinHighComparator(pinHigh), .pinLowComparator(pinLow),
      .gateEnable(gateEnable), .startupCellOn(cellOn),
      .chargeSwitch(chargeSw), .dischargeSwitch(dischargeSw),
      .extBlankDone(extDone), .cycleOdd(cycleOdd), .protectMode(mode));
   par_afe_model afe (.clk(clk), .reset_n(reset_n), .slow(slow),
      .chargeSwitch(chargeSw), .dischargeSwitch(dischargeSw),
      .pinHigh(pinHigh), .pinLow(pinLow));
   // Verdict and end of run
   task reportAndStop();
      if (errorCnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Wait n edges, then settle at the falling edge
   task clks(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask
   // One classic Wishbone cycle; read data lands in rd
   task wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wbCyc <= 1;
      wbStb <= 1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= d;
      wbSel <= 4'hf;
      do
      begin
         @(negedge clk);
      end
      while (wbAck !== 1'b1);
      @(posedge clk);
      rd = wbDatO;
      wbCyc <= 0;
      wbStb <= 0;
   endtask
   // One supply lockout off/on cycle with its expected outcome
   task restart(input logic odd, input logic gate, input par_mode_e m);
      @(posedge clk) supplyOk <= 0;
      clks(3);
      `CHK("cycleOdd", odd, cycleOdd)
      `CHK("startupCellOn", 1'b1, cellOn)
      `CHK("protectMode", m, mode)
      @(posedge clk) supplyOk <= 1;
      clks(3);
      `CHK("gateEnable", gate, gateEnable)
   endtask
   // Hang guard
   always @(posedge clk)
   begin
      tick++;
      if (tick == 20000)
      begin
         errorCnt++;
         reportAndStop();
      end
   end
   // Main sequence
   initial
   begin
      {reset_n, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
      {startOv, hardOv, overTemp, extLow, brownLow, softStart} = '0;
      {overload, slow} = '0;
      supplyOk = 1;
      {errorCnt, compares, tick, pulses} = '0;
      repeat (2) @(posedge clk);
      reset_n <= 1;
      clks(1);
      `CHK("resetMode", MODE_NONE, mode)
      wbXfer(0, 8'h00, 0);
      `CHK("ctrl", 32'h1, rd)
      wbXfer(1, 8'h0c, 32'hffff);
      wbXfer(0, 8'h0c, 0);
      `CHK("unmapped", 32'h0, rd)
      restart(1, 1, MODE_AR);
      `CHK("resumeOdd", 1'b0, cycleOdd)
      @(posedge clk) hardOv <= 1;
      clks(2);
      `CHK("hardOv", MODE_OSAR, mode)
      wbXfer(0, 8'h04, 0);
      `CHK("status", 32'h13, rd)
      restart(1, 0, MODE_OSAR);
      restart(0, 1, MODE_OSAR);
      @(posedge clk) hardOv <= 0;
      restart(1, 0, MODE_OSAR);
      restart(0, 1, MODE_OSAR);
      `CHK("resumeMode", MODE_NONE, mode)
      @(posedge clk) overTemp <= 1;
      clks(2);
      `CHK("overTemp", MODE_OSNS, mode)
      restart(1, 0, MODE_OSNS);
      restart(0, 0, MODE_OSNS);
      @(posedge clk) overTemp <= 0;
      restart(1, 0, MODE_OSNS);
      restart(0, 1, MODE_OSNS);
      wbXfer(1, 8'h00, 0);
      @(posedge clk) extLow <= 1;
      clks(3);
      `CHK("disabled", MODE_NONE, mode)
      wbXfer(1, 8'h00, 1);
      clks(2);
      `CHK("extProtect", MODE_NSAR, mode)
      restart(1, 0, MODE_NSAR);
      @(posedge clk) extLow <= 0;
      restart(0, 1, MODE_NSAR);
      @(posedge clk) brownLow <= 1;
      clks(700);
      `CHK("brownShort", MODE_NONE, mode)
      @(posedge clk) brownLow <= 0;
      @(posedge clk) brownLow <= 1;
      clks(760);
      `CHK("brownout", MODE_NSAR, mode)
      restart(1, 0, MODE_NSAR);
      restart(0, 0, MODE_NSAR);
      @(posedge clk) brownLow <= 0;
      restart(1, 1, MODE_NSAR);
      @(posedge clk) {startOv, overload} <= 2'b11;
      clks(3);
      `CHK("noSoftStart", MODE_NONE, mode)
      @(posedge clk) softStart <= 1;
      clks(2);
      `CHK("startOv", MODE_OSAR, mode)
      @(posedge clk) {startOv, overload, softStart} <= 3'b000;
      restart(1, 0, MODE_OSAR);
      restart(0, 1, MODE_OSAR);
      @(posedge clk) {slow, overload} <= 2'b11;
      clks(BLANK - 3);
      `CHK("earlyDisch", 1'b0, dischargeSw)
      clks(60);
      `CHK("extActive", 1'b1, chargeSw ^ dischargeSw)
      @(posedge clk) overload <= 0;
      clks(3);
      `CHK("abortSw", 2'b00, {chargeSw, dischargeSw})
      wbXfer(0, 8'h08, 0);
      `CHK("abortCount", 32'h0, rd)
      @(posedge clk) {slow, overload} <= 2'b01;
      n = 0;
      prevCh = 0;
      while (extDone !== 1'b1 && n < 4000)
      begin
         @(negedge clk);
         if (prevCh && !chargeSw)
            pulses++;
         prevCh = chargeSw;
         n++;
      end
      `CHK("extDone", 1'b1, extDone)
      `CHK("chargeCycles", 256, pulses)
      `CHK("preSpike", MODE_NONE, mode)
      wbXfer(0, 8'h08, 0);
      `CHK("extCount", 32'h100, rd)
      clks(760);
      `CHK("overloadTrip", MODE_OSAR, mode)
      @(posedge clk) overload <= 0;
      restart(1, 0, MODE_OSAR);
      restart(0, 1, MODE_OSAR);
      `CHK("doneCleared", 1'b0, extDone)
      reportAndStop();
   end
endmodule
`default_nettype wire
